/* rtl/rws_pkg.sv */
// package: constants and types for the reset and watchdog sequencer
package rws_pkg;
   // clock rate in kHz
   localparam int unsigned SYS_CLK_KHZ = 200000;
   // watchdog oscillator, nominal 31 kHz, made as a tick from the system clock
   localparam int unsigned WDOG_OSC_KHZ = 31;
   localparam int unsigned WDOG_TICK_DIV = SYS_CLK_KHZ / WDOG_OSC_KHZ;
   localparam int unsigned WDOG_TICK_W = 16;
   // power-up timer, 64 ms nominal, counted in watchdog oscillator ticks
   localparam int unsigned PWRUP_DELAY_MS = 64;
   localparam int unsigned PWRUP_TICKS = PWRUP_DELAY_MS * WDOG_OSC_KHZ;
   localparam int unsigned PWRUP_W = 12;
   // base watchdog period 17 ms, in oscillator ticks
   localparam int unsigned WDOG_BASE_MS = 17;
   localparam int unsigned WDOG_BASE_TICKS = WDOG_BASE_MS * WDOG_OSC_KHZ;
   localparam int unsigned WDOG_BASE_W = 10;
   // oscillator start-up count, in oscillator-clock cycles (1024 tosc)
   localparam int unsigned OSC_STARTUP_CYCLES = 1024;
   localparam int unsigned OSC_STARTUP_W = 11;
   // master clear glitch filter: least low width in system cycles
   localparam int unsigned MASTER_CLEAR_PIN_FILTER_NS = 2000;
   localparam int unsigned SYS_CLK_NS = 5;
   localparam int unsigned MASTER_CLEAR_PIN_FILTER_CYC = (MASTER_CLEAR_PIN_FILTER_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
   localparam int unsigned MASTER_CLEAR_PIN_FILTER_W = 9;
   // prescaler
   localparam int unsigned PRESC_W = 8;
   localparam int unsigned RATE_W = 3;
   // program counter and vectors
   localparam int unsigned PC_W = 13;
   localparam logic [12:0] PC_RESET_VEC = 13'h0000;
   localparam logic [12:0] PC_IRQ_VEC = 13'h0004;
   // status byte values (unknown bits taken as 0 on power-on)
   localparam logic [7:0] STAT_POR_VAL = 8'h18;
   localparam logic [7:0] STAT_SLEEP_MASTER_CLEAR_PIN_VAL = 8'h10;
   localparam logic [7:0] STAT_WDT_RST_VAL = 8'h08;
   localparam int unsigned STAT_IRP = 7;
   localparam int unsigned STAT_TO = 4;
   localparam int unsigned STAT_PD = 3;
   // clock source selection
   typedef enum logic [2:0] {
      RWS_CLK_EXT_RC = 3'h0,
      RWS_CLK_INT_OSC = 3'h1,
      RWS_CLK_EXT_CLK = 3'h2,
      RWS_CLK_TMR1_OSC = 3'h3,
      RWS_CLK_CRYSTAL = 3'h4,
      RWS_CLK_HS_CRYSTAL = 3'h5,
      RWS_CLK_LP_CRYSTAL = 3'h6
   } rws_clk_src_t;
   // reset sequence states, gray along power-on path
   typedef enum logic [1:0] {
      RWS_ST_POR = 2'b00,
      RWS_ST_PWRUP = 2'b01,
      RWS_ST_OSC = 2'b11,
      RWS_ST_RUN = 2'b10
   } rws_state_t;
endpackage

/* rtl/rws_reset_watchdog_sequencer.sv */
// module: reset, power-up timer, master clear filter and watchdog sequencer
`timescale 1ns/1ps
module rws_reset_watchdog_sequencer
   import rws_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst,
   // supply detectors
   input wire logic i_supply_good,
   input wire logic i_brownout_trip,
   // master clear pin, input only
   input wire logic i_master_clear_pin_n,
   output logic o_master_clear_pin,
   output logic o_master_clear_pin_oe_n,
   // configuration
   input wire logic i_external_reset_pin_select,
   input wire logic i_power_up_delay_disable,
   input wire logic i_watchdog_enable_cfg,
   input wire logic [2:0] i_clk_src,
   // option bits
   input wire logic i_prescaler_assign,
   input wire logic [RATE_W-1:0] i_prescaler_rate,
   input wire logic i_timer0_tick,
   // core control
   input wire logic i_watchdog_clear_instruction,
   input wire logic i_sleep_enter,
   input wire logic i_irq_wake,
   input wire logic i_global_interrupt_enable,
   input wire logic [PC_W-1:0] i_pc,
   input wire logic i_power_flag_set,
   input wire logic i_brownout_flag_set,
   // reset outputs to the core
   output logic o_core_reset,
   output logic o_pc_load,
   output logic [PC_W-1:0] o_pc_value,
   output logic o_push_return,
   output logic o_status_load,
   output logic [7:0] o_status_value,
   output logic [7:0] o_status_keep_mask,
   output logic o_regs_reset,
   // cause flags
   output logic o_power_flag,
   output logic o_brownout_flag,
   output logic o_timeout_flag,
   output logic o_sleep_entry_flag,
   // timer0 prescaled tick and sleep state
   output logic o_timer0_presc_tick,
   output logic o_sleeping
);

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers for pins and detectors

   logic [2:0] master_clear_pin_sync_reg;
   logic [2:0] good_sync_reg;
   logic [2:0] bor_sync_reg;
   logic master_clear_pin_low;
   logic supply_ok;
   logic bor_trip;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         master_clear_pin_sync_reg <= 3'h7;
         good_sync_reg <= 3'h0;
         bor_sync_reg <= 3'h0;
      end else begin
         master_clear_pin_sync_reg <= {master_clear_pin_sync_reg[1:0], i_master_clear_pin_n};
         good_sync_reg <= {good_sync_reg[1:0], i_supply_good};
         bor_sync_reg <= {bor_sync_reg[1:0], i_brownout_trip};
      end
   end

   logic master_clear_pin_low_reg;
   logic supply_ok_reg;
   logic bor_trip_reg;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         master_clear_pin_low_reg <= 1'b0;
         supply_ok_reg <= 1'b0;
         bor_trip_reg <= 1'b0;
      end else begin
         if (master_clear_pin_sync_reg[1] == master_clear_pin_sync_reg[2]) begin
            master_clear_pin_low_reg <= ~master_clear_pin_sync_reg[2];
         end
         if (good_sync_reg[1] == good_sync_reg[2]) begin
            supply_ok_reg <= good_sync_reg[2];
         end
         if (bor_sync_reg[1] == bor_sync_reg[2]) begin
            bor_trip_reg <= bor_sync_reg[2];
         end
      end
   end

   assign master_clear_pin_low = master_clear_pin_low_reg;
   assign supply_ok = supply_ok_reg;
   assign bor_trip = bor_trip_reg;

   // pin is never driven by the device
   assign o_master_clear_pin = 1'b1;
   assign o_master_clear_pin_oe_n = 1'b1;

   ////////////////////////////////////////////////////////////////////////////
   // master clear glitch filter

   logic [MASTER_CLEAR_PIN_FILTER_W-1:0] master_clear_pin_cnt_reg;
   logic master_clear_pin_active_reg;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         master_clear_pin_cnt_reg <= '0;
         master_clear_pin_active_reg <= 1'b0;
      end else if (!i_external_reset_pin_select || !master_clear_pin_low) begin
         master_clear_pin_cnt_reg <= '0;
         master_clear_pin_active_reg <= 1'b0;
      end else if (master_clear_pin_cnt_reg == MASTER_CLEAR_PIN_FILTER_W'(MASTER_CLEAR_PIN_FILTER_CYC - 1)) begin
         master_clear_pin_active_reg <= 1'b1;
      end else begin
         master_clear_pin_cnt_reg <= master_clear_pin_cnt_reg + 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // watchdog oscillator tick

   logic [WDOG_TICK_W-1:0] osc_div_reg;
   logic osc_tick;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         osc_div_reg <= '0;
      end else if (osc_div_reg == WDOG_TICK_W'(WDOG_TICK_DIV - 1)) begin
         osc_div_reg <= '0;
      end else begin
         osc_div_reg <= osc_div_reg + 1'b1;
      end
   end

   assign osc_tick = (osc_div_reg == WDOG_TICK_W'(WDOG_TICK_DIV - 1));

   function automatic logic is_crystal(input logic [2:0] src);
      is_crystal = (src == RWS_CLK_CRYSTAL) || (src == RWS_CLK_HS_CRYSTAL) ||
                   (src == RWS_CLK_LP_CRYSTAL);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // reset sequence

   rws_state_t state_reg;
   logic [PWRUP_W-1:0] pwrup_cnt_reg;
   logic [OSC_STARTUP_W-1:0] ost_cnt_reg;
   logic sleeping_reg;
   logic wdog_timeout;
   logic wdog_reset_evt;
   logic wake_evt;
   logic sleep_master_clear_pin;
   logic ost_done;

   assign ost_done = (ost_cnt_reg == OSC_STARTUP_W'(OSC_STARTUP_CYCLES - 1));

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= RWS_ST_POR;
         pwrup_cnt_reg <= '0;
         ost_cnt_reg <= '0;
      end else if (!supply_ok || bor_trip) begin
         state_reg <= RWS_ST_POR;
         pwrup_cnt_reg <= '0;
         ost_cnt_reg <= '0;
      end else begin
         case (state_reg)
            RWS_ST_POR: begin
               pwrup_cnt_reg <= '0;
               ost_cnt_reg <= '0;
               if (i_power_up_delay_disable) begin
                  state_reg <= RWS_ST_OSC;
               end else begin
                  state_reg <= RWS_ST_PWRUP;
               end
            end
            RWS_ST_PWRUP: begin
               if (osc_tick) begin
                  pwrup_cnt_reg <= pwrup_cnt_reg + 1'b1;
                  if (pwrup_cnt_reg == PWRUP_W'(PWRUP_TICKS - 1)) begin
                     state_reg <= RWS_ST_OSC;
                  end
               end
            end
            RWS_ST_OSC: begin
               if (!is_crystal(i_clk_src) || ost_done) begin
                  state_reg <= RWS_ST_RUN;
               end else begin
                  ost_cnt_reg <= ost_cnt_reg + 1'b1;
               end
            end
            RWS_ST_RUN: begin
               if (wake_evt && is_crystal(i_clk_src)) begin
                  ost_cnt_reg <= '0;
                  state_reg <= RWS_ST_OSC;
               end
            end
            default: state_reg <= RWS_ST_POR;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // sleep tracking and wake / reset events

   assign wdog_reset_evt = wdog_timeout && !sleeping_reg;
   assign wake_evt = sleeping_reg && (wdog_timeout || i_irq_wake);
   assign sleep_master_clear_pin = sleeping_reg && master_clear_pin_active_reg;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         sleeping_reg <= 1'b0;
      end else if (o_core_reset || wake_evt) begin
         sleeping_reg <= master_clear_pin_active_reg && master_clear_pin_low && sleeping_reg;
      end else if (i_sleep_enter && state_reg == RWS_ST_RUN) begin
         sleeping_reg <= 1'b1;
      end
   end

   assign o_sleeping = sleeping_reg;
   assign o_core_reset = (state_reg != RWS_ST_RUN) || master_clear_pin_active_reg || wdog_reset_evt;

   ////////////////////////////////////////////////////////////////////////////
   // shared prescaler and watchdog counter

   logic [PRESC_W-1:0] presc_reg;
   logic [WDOG_BASE_W-1:0] wdog_cnt_reg;
   logic wdog_held;
   logic wdog_clear;
   logic wdog_base_done;
   logic presc_hit;

   assign wdog_held = (state_reg != RWS_ST_RUN);
   assign wdog_clear = !i_watchdog_enable_cfg || i_watchdog_clear_instruction ||
                       wake_evt || wdog_held || o_core_reset;
   assign wdog_base_done = osc_tick && (wdog_cnt_reg == WDOG_BASE_W'(WDOG_BASE_TICKS - 1));

   // prescaler output bit: watchdog 1:1..1:128, timer0 1:2..1:256
   function automatic logic presc_match(input logic [PRESC_W-1:0] cnt,
                                        input logic [RATE_W-1:0] rate,
                                        input logic for_wdog);
      logic [PRESC_W:0] mask;
      mask = '0;
      mask = (9'h001 << ({1'b0, rate} + {3'h0, !for_wdog})) - 9'h001;
      presc_match = ((cnt & mask[PRESC_W-1:0]) == mask[PRESC_W-1:0]);
   endfunction

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         wdog_cnt_reg <= '0;
      end else if (wdog_clear || wdog_base_done) begin
         wdog_cnt_reg <= '0;
      end else if (osc_tick) begin
         wdog_cnt_reg <= wdog_cnt_reg + 1'b1;
      end
   end

   // prescaler counts watchdog base periods or timer0 ticks
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         presc_reg <= '0;
      end else if (i_prescaler_assign) begin
         if (wdog_clear) begin
            presc_reg <= '0;
         end else if (wdog_base_done) begin
            presc_reg <= presc_hit ? '0 : presc_reg + 1'b1;
         end
      end else if (i_timer0_tick) begin
         presc_reg <= presc_hit ? '0 : presc_reg + 1'b1;
      end
   end

   assign presc_hit = presc_match(presc_reg, i_prescaler_rate, i_prescaler_assign);
   assign wdog_timeout = i_prescaler_assign ? (wdog_base_done && presc_hit && !wdog_clear)
                                            : (wdog_base_done && !wdog_clear);
   assign o_timer0_presc_tick = i_timer0_tick && (i_prescaler_assign || presc_hit);

   ////////////////////////////////////////////////////////////////////////////
   // cause flags

   logic power_flag_reg;
   logic bor_flag_reg;
   logic to_flag_reg;
   logic pd_flag_reg;
   logic por_reset;
   logic bor_reset;

   assign por_reset = !supply_ok;
   assign bor_reset = supply_ok && bor_trip;

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         power_flag_reg <= 1'b0;
         bor_flag_reg <= 1'b0;
      end else if (por_reset) begin
         power_flag_reg <= 1'b0;
      end else if (bor_reset) begin
         bor_flag_reg <= 1'b0;
      end else begin
         if (i_power_flag_set) begin
            power_flag_reg <= 1'b1;
         end
         if (i_brownout_flag_set) begin
            bor_flag_reg <= 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         to_flag_reg <= 1'b1;
         pd_flag_reg <= 1'b1;
      end else if (por_reset || bor_reset) begin
         to_flag_reg <= 1'b1;
         pd_flag_reg <= 1'b1;
      end else if (wdog_reset_evt) begin
         to_flag_reg <= 1'b0;
         pd_flag_reg <= 1'b1;
      end else if (sleeping_reg && wdog_timeout) begin
         to_flag_reg <= 1'b0;
         pd_flag_reg <= 1'b0;
      end else if (sleep_master_clear_pin || (sleeping_reg && i_irq_wake)) begin
         to_flag_reg <= 1'b1;
         pd_flag_reg <= 1'b0;
      end else if (i_watchdog_clear_instruction) begin
         to_flag_reg <= 1'b1;
         pd_flag_reg <= 1'b1;
      end else if (i_sleep_enter && state_reg == RWS_ST_RUN && !sleeping_reg) begin
         to_flag_reg <= 1'b1;
         pd_flag_reg <= 1'b0;
      end
   end

   assign o_power_flag = power_flag_reg;
   assign o_brownout_flag = bor_flag_reg;
   assign o_timeout_flag = to_flag_reg;
   assign o_sleep_entry_flag = pd_flag_reg;

   ////////////////////////////////////////////////////////////////////////////
   // program counter and status loads for the core

   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         o_pc_load <= 1'b1;
         o_pc_value <= PC_RESET_VEC;
         o_push_return <= 1'b0;
         o_status_load <= 1'b1;
         o_status_value <= STAT_POR_VAL;
         o_status_keep_mask <= 8'h00;
         o_regs_reset <= 1'b1;
      end else begin
         o_push_return <= 1'b0;
         o_pc_load <= 1'b0;
         o_status_load <= 1'b0;
         o_regs_reset <= 1'b0;
         if (por_reset || bor_reset) begin
            o_pc_load <= 1'b1;
            o_pc_value <= PC_RESET_VEC;
            o_status_load <= 1'b1;
            o_status_value <= STAT_POR_VAL;
            o_status_keep_mask <= por_reset ? 8'h00 : 8'h07;
            o_regs_reset <= 1'b1;
         end else if (master_clear_pin_active_reg || wdog_reset_evt) begin
            o_pc_load <= 1'b1;
            o_pc_value <= PC_RESET_VEC;
            o_status_load <= 1'b1;
            o_regs_reset <= 1'b1;
            if (wdog_reset_evt) begin
               o_status_value <= STAT_WDT_RST_VAL;
               o_status_keep_mask <= 8'h07;
            end else if (sleeping_reg) begin
               o_status_value <= STAT_SLEEP_MASTER_CLEAR_PIN_VAL;
               o_status_keep_mask <= 8'h07;
            end else begin
               o_status_value <= 8'h00;
               o_status_keep_mask <= 8'h1f;
            end
         end else if (wake_evt) begin
            o_pc_load <= 1'b1;
            o_status_load <= 1'b1;
            o_status_value <= {3'h0, ~wdog_timeout, 4'h0};
            o_status_keep_mask <= 8'he7;
            if (i_irq_wake && i_global_interrupt_enable && !wdog_timeout) begin
               o_push_return <= 1'b1;
               o_pc_value <= PC_IRQ_VEC;
            end else begin
               o_pc_value <= i_pc + 1'b1;
            end
         end
      end
   end

endmodule

/* tb/rws_assertions.sv */
// checker: port-level assertions for the reset and watchdog sequencer
`timescale 1ns/1ps
module rws_assertions
   import rws_pkg::*;
(
   // clock, reset, inputs
   input wire logic i_clk_sys,
   input wire logic i_rst,
   input wire logic i_supply_good,
   input wire logic i_master_clear_pin_n,
   input wire logic i_external_reset_pin_select,
   input wire logic i_prescaler_assign,
   input wire logic i_timer0_tick,
   input wire logic i_watchdog_clear_instruction,
   // outputs watched
   input wire logic o_master_clear_pin,
   input wire logic o_master_clear_pin_oe_n,
   input wire logic o_core_reset,
   input wire logic o_pc_load,
   input wire logic [PC_W-1:0] o_pc_value,
   input wire logic o_push_return,
   input wire logic o_status_load,
   input wire logic [7:0] o_status_value,
   input wire logic [7:0] o_status_keep_mask,
   input wire logic o_power_flag,
   input wire logic o_timeout_flag,
   input wire logic o_sleep_entry_flag,
   input wire logic o_timer0_presc_tick,
   input wire logic o_sleeping
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_rst);
   ////////////////////////////////////////////////////////////////////////////////
   // width of a qualified low on the pin
   logic [9:0] low_cnt_reg;
   always_ff @(posedge i_clk_sys or posedge i_rst) begin
      if (i_rst) begin
         low_cnt_reg <= 10'h000;
      end else if (i_external_reset_pin_select && !i_master_clear_pin_n) begin
         if (low_cnt_reg != 10'h3ff) begin
            low_cnt_reg <= low_cnt_reg + 10'h001;
         end
      end else begin
         low_cnt_reg <= 10'h000;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   a_pin_not_driven: assert property (o_master_clear_pin_oe_n && o_master_clear_pin)
      else $error("master clear pin driven");
   a_por_flag_set: assert property ($fell(i_rst) |->
      !o_power_flag && o_timeout_flag && o_sleep_entry_flag)
      else $error("power-on flag set wrong");
   a_supply_hold: assert property (!i_supply_good [*8] |-> o_core_reset)
      else $error("core left reset while supply low");
   a_por_flag_low: assert property (!i_supply_good [*8] |-> !o_power_flag)
      else $error("power flag not cleared by supply loss");
   a_master_clear_pin_long: assert property (low_cnt_reg > 10'(MASTER_CLEAR_PIN_FILTER_CYC + 8) |->
      o_core_reset)
      else $error("long master clear low gave no reset");
   a_push_vector: assert property (o_push_return |->
      o_pc_load && o_pc_value == PC_IRQ_VEC)
      else $error("interrupt vector not loaded with push");
   a_status_top: assert property (o_status_load |->
      o_status_value[7:5] == 3'h0 || o_status_keep_mask[7:5] == 3'h7)
      else $error("status upper bits wrong");
   a_clear_flags: assert property (i_watchdog_clear_instruction &&
      !o_core_reset && !o_sleeping |-> ##[1:3] (o_timeout_flag && o_sleep_entry_flag))
      else $error("clear instruction flags wrong");
   a_sleep_flags: assert property ($rose(o_sleeping) |->
      ##[0:1] (o_timeout_flag && !o_sleep_entry_flag))
      else $error("sleep entry flags wrong");
   a_presc_wdog: assert property (i_prescaler_assign |->
      o_timer0_presc_tick == i_timer0_tick)
      else $error("timer0 not 1:1 with prescaler on watchdog");
   a_reset_ends_sleep: assert property ($fell(o_core_reset) |-> !o_sleeping)
      else $error("sleep kept after reset");
endmodule

bind rws_reset_watchdog_sequencer rws_assertions chk_u (.*);

/* tb/rws_pin_model.sv */
// partner: master clear pin with weak pull-up and external driver
`timescale 1ns/1ps
module rws_pin_model (
   // drivers
   input wire logic i_pull_low,
   input wire logic i_dev_drive,
   input wire logic i_dev_oe_n,
   // resolved pin
   output logic o_pin_n
);
   // external switch wins, device drives only when enabled, else pull-up
   assign o_pin_n = i_pull_low ? 1'b0 : (!i_dev_oe_n ? i_dev_drive : 1'b1);
endmodule

/* tb/rws_reset_watchdog_sequencer_tb.sv */
// testbench: reset sequencing, pin filter, sleep, wake and prescaler
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end
module rws_reset_watchdog_sequencer_tb
   import rws_pkg::*;
;
   logic clk, rst, sup, bor, pull, sel, pdd, wen, asg, t0, clr, slp, irq, global_interrupt_enable, pfs, bfs, pin_n;
   logic [2:0] src, rate;
   logic [PC_W-1:0] pc, pcv, last_pc;
   logic pin_o, pin_oe_n, crst, pcl, push, stl, regs, pf, bf, tof, sef, ptick, sleeping, last_push;
   logic [7:0] stv, stk, last_st, last_k;
   int num_errors = 0, compares = 0, rst_cnt = 0, p_cnt = 0;

   rws_pin_model pin_u (.i_pull_low(pull), .i_dev_drive(pin_o), .i_dev_oe_n(pin_oe_n),
      .o_pin_n(pin_n));
   rws_reset_watchdog_sequencer dut_u (.i_clk_sys(clk), .i_rst(rst), .i_supply_good(sup),
      .i_brownout_trip(bor), .i_master_clear_pin_n(pin_n), .o_master_clear_pin(pin_o),
      .o_master_clear_pin_oe_n(pin_oe_n), .i_external_reset_pin_select(sel),
      .i_power_up_delay_disable(pdd), .i_watchdog_enable_cfg(wen), .i_clk_src(src),
      .i_prescaler_assign(asg), .i_prescaler_rate(rate), .i_timer0_tick(t0),
      .i_watchdog_clear_instruction(clr), .i_sleep_enter(slp), .i_irq_wake(irq),
      .i_global_interrupt_enable(global_interrupt_enable), .i_pc(pc), .i_power_flag_set(pfs),
      .i_brownout_flag_set(bfs), .o_core_reset(crst), .o_pc_load(pcl), .o_pc_value(pcv),
      .o_push_return(push), .o_status_load(stl), .o_status_value(stv),
      .o_status_keep_mask(stk), .o_regs_reset(regs), .o_power_flag(pf),
      .o_brownout_flag(bf), .o_timeout_flag(tof), .o_sleep_entry_flag(sef),
      .o_timer0_presc_tick(ptick), .o_sleeping(sleeping));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // capture loads, count reset and prescaler cycles
   always @(posedge clk) begin
      if (crst === 1'b1) rst_cnt++;
      if (ptick === 1'b1) p_cnt++;
      if (pcl === 1'b1) begin
         last_pc <= pcv;
         last_push <= push;
      end
      if (stl === 1'b1) begin
         last_st <= stv;
         last_k <= stk;
      end
   end
   ////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      if (num_errors == 0 && compares > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task pulse(input int k);
      @(posedge clk);
      case (k)
         0: slp <= 1'b1;
         1: irq <= 1'b1;
         2: clr <= 1'b1;
         default: begin
            pfs <= 1'b1;
            bfs <= 1'b1;
         end
      endcase
      @(posedge clk);
      {slp, irq, clr, pfs, bfs} <= 5'h00;
      cyc(4);
   endtask
   task wait_idle(output int n);
      n = 0;
      while (crst !== 1'b0 && n < 5000) begin
         @(posedge clk);
         n++;
      end
      if (n >= 5000) begin
         num_errors++;
         end_sim();
      end
   endtask
   task master_clear_pin(input int n);
      int w;
      @(posedge clk) pull <= 1'b1;
      cyc(n);
      pull <= 1'b0;
      cyc(20);
      wait_idle(w);
   endtask
   task flags(input logic [3:0] e);
      `CHK({pf, bf, tof, sef}, e)
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      int n, base;
      {rst, sel, pdd} = 3'h7;
      {sup, bor, pull, wen, asg, t0, clr, slp, irq, global_interrupt_enable, pfs, bfs} = 12'h000;
      src = RWS_CLK_INT_OSC;
      rate = 3'h0;
      pc = 13'h0123;
      cyc(6);
      flags(4'h3);
      `CHK({crst, stv, pin_oe_n, regs}, {1'b1, STAT_POR_VAL, 1'b1, 1'b1})
      rst <= 1'b0;
      cyc(50);
      `CHK(crst, 1'b1)
      sup <= 1'b1;
      wait_idle(n);
      pulse(3);
      flags(4'hf);
      // timer0 rates, then 1:1 with prescaler on watchdog
      for (int r = 0; r < 9; r++) begin
         @(posedge clk);
         asg <= (r == 8);
         rate <= 3'(r % 8);
         cyc(2);
         base = p_cnt;
         repeat (256) begin
            @(posedge clk) t0 <= 1'b1;
            @(posedge clk) t0 <= 1'b0;
         end
         cyc(2);
         `CHK(p_cnt - base, (r == 8) ? 256 : (256 >> (r + 1)))
      end
      wen <= 1'b1;
      // short low rejected, long low ignored with pin deselected
      base = rst_cnt;
      master_clear_pin(MASTER_CLEAR_PIN_FILTER_CYC / 2);
      `CHK(rst_cnt - base, 0)
      @(posedge clk) sel <= 1'b0;
      master_clear_pin(MASTER_CLEAR_PIN_FILTER_CYC + 100);
      `CHK(rst_cnt - base, 0)
      @(posedge clk) sel <= 1'b1;
      master_clear_pin(MASTER_CLEAR_PIN_FILTER_CYC + 100);
      `CHK({last_pc, last_st[7:5], last_k}, {PC_RESET_VEC, 3'h0, 8'h1f})
      flags(4'hf);
      // master clear during sleep
      pulse(0);
      `CHK(sleeping, 1'b1)
      master_clear_pin(MASTER_CLEAR_PIN_FILTER_CYC + 100);
      `CHK({last_st[7:3], last_k, sleeping}, {5'h02, 8'h07, 1'b0})
      flags(4'he);
      pulse(2);
      flags(4'hf);
      // interrupt wake with and without global enable
      @(posedge clk) global_interrupt_enable <= 1'b1;
      pulse(0);
      pulse(1);
      cyc(30);
      `CHK({last_pc, last_push}, {PC_IRQ_VEC, 1'b1})
      flags(4'he);
      @(posedge clk) global_interrupt_enable <= 1'b0;
      pulse(0);
      pulse(1);
      cyc(30);
      `CHK({last_pc, last_push}, {13'h0124, 1'b0})
      // brown-out, then brown-out with crystal start-up
      @(posedge clk) bor <= 1'b1;
      cyc(20);
      bor <= 1'b0;
      cyc(2);
      wait_idle(n);
      flags(4'hb);
      `CHK({last_pc, last_st[7:3], last_k}, {PC_RESET_VEC, 5'h03, 8'h07})
      @(posedge clk) begin
         src <= RWS_CLK_CRYSTAL;
         bor <= 1'b1;
      end
      cyc(20);
      bor <= 1'b0;
      wait_idle(n);
      `CHK(n >= OSC_STARTUP_CYCLES, 1'b1)
      end_sim();
   end
   initial begin
      cyc(60000);
      num_errors++;
      end_sim();
   end
endmodule
